/* status_params.svh */
// constants for the status and event reporting block
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

`define NUM_CH       4
`define CH_IDX_W     2
`define COND_W       16
`define BYTE_W       8

// quality condition bit positions
`define Q_VERR_BIT   0
`define Q_VMODE_BIT  8
`define Q_RELAY_BIT  9
`define Q_CMODE_BIT  10
`define Q_ROLL_BIT   13
`define Q_WARN_BIT   14

// run-state condition bit positions
`define R_CV_BIT     8
`define R_RELAY_BIT  9
`define R_CC_BIT     10
`define RUN_USED     16'h0700

// status byte bit positions
`define SB_QUES_BIT  3
`define SB_MAV_BIT   4
`define SB_STD_BIT   5
`define SB_RQS_BIT   6
`define SB_RUN_STATE_REGISTER_BIT  7
`define RQS_EXCL     8'hbf

// event blocking and reset values
`define NOEVT_MASK   16'h0400
`define MASK16_RST   16'h0000
`define MASK8_RST    8'h00
`define CHMASK_RST   16'hffff

`endif

/* status_pkg.sv */
// types shared by the status reporting modules
`default_nettype none

package status_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [3:0] {
    SEL_QCOND,
    SEL_QEVT,
    SEL_QMASK,
    SEL_RCOND,
    SEL_REVT,
    SEL_RMASK,
    SEL_SEVT,
    SEL_SMASK,
    SEL_SRBYTE,
    SEL_SRMASK,
    SEL_ROLL,
    SEL_CHSUM,
    SEL_CHMASK
  } regsel_t;
endpackage

`default_nettype wire

/* status_if.sv */
// carriers between the status top and its event and request submodules
`default_nettype none

interface evt_if #(parameter int W = 16) ();
  logic [W-1:0] cond;
  logic [W-1:0] mask;
  logic         clr;
  logic [W-1:0] evt;
  logic         summary;
  modport latch (input cond, mask, clr, output evt, summary);
  modport owner (output cond, mask, clr, input evt, summary);
endinterface

interface srq_if ();
  logic [7:0] byteIn;
  logic [7:0] mask;
  logic [7:0] srByte;
  logic       srq;
  modport gen   (input byteIn, mask, output srByte, srq);
  modport owner (output byteIn, mask, input srByte, srq);
endinterface

`default_nettype wire

/* event_latch.sv */
// masked rising-edge event register, cleared by a read strobe
`default_nettype none

module event_latch #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  evt_if.latch     e
);
  logic [W-1:0] prevCond;
  logic [W-1:0] evtReg;
  wire  [W-1:0] rise;
  wire  [W-1:0] next_evt;

  assign rise     = e.cond & ~prevCond & e.mask;
  assign next_evt = (e.clr ? '0 : evtReg) | rise;
  assign e.evt     = evtReg;
  assign e.summary = |evtReg;

  always_ff @(posedge clk) begin
    if (rst) begin
      prevCond <= '0;
      evtReg   <= '0;
    end else begin
      prevCond <= e.cond;
      evtReg   <= next_evt;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  a_rise_latch: assert property (@(posedge clk) disable iff (rst)
    (|rise) |=> ((evtReg & $past(rise)) == $past(rise)))
    else $error("enabled rising condition not latched");
  a_read_clear: assert property (@(posedge clk) disable iff (rst)
    (e.clr && rise == '0) |=> (evtReg == '0))
    else $error("event register not cleared by read");
  a_masked_only: assert property (@(posedge clk) disable iff (rst)
    ##1 (((evtReg & ~$past(evtReg)) & ~$past(e.mask)) == '0))
    else $error("event set through a zero mask bit");
endmodule

`default_nettype wire

/* srq_gen.sv */
// service request byte with summary bit and request line
`include "status_params.svh"
`default_nettype none

module srq_gen (
  input wire logic clk,
  input wire logic rst,
  srq_if.gen       s
);
  logic [7:0] byteReg;
  logic       srqReg;
  wire        rqs;
  wire  [7:0] next_byte;

  assign rqs       = |(s.byteIn & s.mask & `RQS_EXCL);
  assign next_byte = (s.byteIn & `RQS_EXCL) | ({7'h00, rqs} << `SB_RQS_BIT);
  assign s.srByte  = byteReg;
  assign s.srq     = srqReg;

  always_ff @(posedge clk) begin
    if (rst) begin
      byteReg <= 8'h00;
      srqReg  <= 1'b0;
    end else begin
      byteReg <= next_byte;
      srqReg  <= rqs;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  sequence reqUp;
    rqs;
  endsequence
  sequence reqGone;
    !rqs;
  endsequence

  a_srq_raise: assert property (@(posedge clk) disable iff (rst)
    reqUp |=> (srqReg && byteReg[`SB_RQS_BIT]))
    else $error("request line not raised");
  a_srq_release: assert property (@(posedge clk) disable iff (rst)
    reqGone |=> (!srqReg && !byteReg[`SB_RQS_BIT]))
    else $error("request line not released");
  a_rqs_reduce: assert property (@(posedge clk) disable iff (rst)
    ##1 (byteReg[`SB_RQS_BIT] == |($past(s.byteIn) & $past(s.mask) & `RQS_EXCL)))
    else $error("summary bit is not the masked reduction");
endmodule

`default_nettype wire

/* status_event_reporting.sv */
// status and event reporting hierarchy with service request generation
`include "status_params.svh"
`default_nettype none

module status_event_reporting (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             constVolt,
  input  wire logic                             relayClosed,
  input  wire logic                             constCurr,
  input  wire logic                             voltErr,
  input  wire logic                             commandWarning,
  input  wire logic                             errQueueNotEmpty,
  input  wire logic                             msgAvailable,
  input  wire logic [7:0]                       stdCond,
  input  wire logic [`NUM_CH-1:0][15:0]         chanSummary,
  input  wire logic                             multiOn,
  input  wire logic                             multiOff,
  input  wire logic                             defaultsLoad,
  input  wire status_pkg::regsel_t              regSel,
  input  wire logic [`CH_IDX_W-1:0]             regChan,
  input  wire logic                             regRead,
  input  wire logic                             regWrite,
  input  wire logic [15:0]                      regWData,
  output var  logic [15:0]                      rdData,
  output var  logic                             rdValid,
  output logic [7:0]                            statusByte,
  output logic                                  srq,
  output var  logic                             multiMode
);

  // ***********************************
  // pin synchronisers
  // ***********************************
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  wire        cvS;
  wire        relayS;
  wire        ccS;
  wire        verrS;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      pinMeta <= {voltErr, constCurr, relayClosed, constVolt};
      pinSync <= pinMeta;
    end
  end

  assign cvS    = pinSync[0];
  assign relayS = pinSync[1];
  assign ccS    = pinSync[2];
  assign verrS  = pinSync[3];

  // ***********************************
  // registers
  // ***********************************
  status_pkg::word_t        runStateCondition;
  status_pkg::word_t        qualityCondition;
  status_pkg::word_t        qMask;
  status_pkg::word_t        oMask;
  status_pkg::byte_t        sMask;
  status_pkg::byte_t        srMask;
  logic [`NUM_CH-1:0][15:0] chanMask;
  logic [`NUM_CH-1:0]       rollup;

  // ***********************************
  // condition composition
  // ***********************************
  status_pkg::word_t           singleQ;
  status_pkg::word_t           multiQ;
  status_pkg::word_t           next_quality;
  status_pkg::word_t           next_runState;
  wire [`NUM_CH:0][15:0]       orChain;
  wire [`NUM_CH-1:0]           next_rollup;

  assign singleQ = (16'h0001 << `Q_VERR_BIT) & {16{verrS}}
                 | (16'h0001 << `Q_VMODE_BIT) & {16{cvS}}
                 | (16'h0001 << `Q_RELAY_BIT) & {16{relayS}}
                 | (16'h0001 << `Q_CMODE_BIT) & {16{ccS}}
                 | (16'h0001 << `Q_WARN_BIT) & {16{commandWarning}};

  assign orChain[0] = 16'h0000;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch++) begin : g_chan
      assign orChain[ch+1]   = orChain[ch] | chanSummary[ch];
      assign next_rollup[ch] = |(chanSummary[ch] & chanMask[ch]);
    end
  endgenerate

  assign multiQ = orChain[`NUM_CH]
                | ((16'h0001 << `Q_ROLL_BIT) & {16{|rollup}});
  assign next_quality = multiMode ? multiQ : singleQ;

  assign next_runState = ((16'h0001 << `R_CV_BIT) & {16{cvS}}
                        | (16'h0001 << `R_RELAY_BIT) & {16{relayS}}
                        | (16'h0001 << `R_CC_BIT) & {16{ccS}})
                        & `RUN_USED;

  always_ff @(posedge clk) begin
    if (rst) begin
      qualityCondition  <= 16'h0000;
      runStateCondition <= 16'h0000;
      rollup            <= '0;
    end else begin
      qualityCondition  <= next_quality;
      runStateCondition <= next_runState;
      rollup            <= next_rollup;
    end
  end

  // ***********************************
  // mode selection
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      multiMode <= 1'b0;
    end else if (multiOn) begin
      multiMode <= 1'b1;
    end else if (multiOff) begin
      multiMode <= 1'b0;
    end
  end

  // ***********************************
  // event registers
  // ***********************************
  evt_if #(.W(16)) quesE ();
  evt_if #(.W(16)) operE ();
  evt_if #(.W(8))  stdE ();

  wire readQEvt;
  wire readREvt;
  wire readSEvt;

  assign readQEvt = regRead && (regSel == status_pkg::SEL_QEVT) && !multiMode;
  assign readREvt = regRead && (regSel == status_pkg::SEL_REVT);
  assign readSEvt = regRead && (regSel == status_pkg::SEL_SEVT);

  assign quesE.cond = qualityCondition;
  assign quesE.mask = qMask & ~`NOEVT_MASK;
  assign quesE.clr  = readQEvt;
  assign operE.cond = runStateCondition;
  assign operE.mask = oMask;
  assign operE.clr  = readREvt;
  assign stdE.cond  = stdCond;
  assign stdE.mask  = sMask;
  assign stdE.clr   = readSEvt;

  event_latch #(.W(16)) u_ques (.clk(clk), .rst(rst), .e(quesE));
  event_latch #(.W(16)) u_run_state_register (.clk(clk), .rst(rst), .e(operE));
  event_latch #(.W(8))  u_std  (.clk(clk), .rst(rst), .e(stdE));

  // ***********************************
  // status byte and request
  // ***********************************
  srq_if srqC ();
  wire   quesSum;

  assign quesSum = multiMode ? |(qualityCondition & qMask) : quesE.summary;

  assign srqC.byteIn = ({7'h00, quesSum | errQueueNotEmpty} << `SB_QUES_BIT)
                     | ({7'h00, msgAvailable} << `SB_MAV_BIT)
                     | ({7'h00, stdE.summary} << `SB_STD_BIT)
                     | ({7'h00, operE.summary} << `SB_RUN_STATE_REGISTER_BIT);
  assign srqC.mask   = srMask;

  srq_gen u_srq (.clk(clk), .rst(rst), .s(srqC));

  assign statusByte = srqC.srByte;
  assign srq        = srqC.srq;

  // ***********************************
  // register access
  // ***********************************
  wire [15:0] rdMux;
  wire [15:0] qEvtView;

  assign qEvtView = multiMode ? qualityCondition : quesE.evt;

  assign rdMux =
    (regSel == status_pkg::SEL_QCOND)  ? qualityCondition :
    (regSel == status_pkg::SEL_QEVT)   ? qEvtView :
    (regSel == status_pkg::SEL_QMASK)  ? qMask :
    (regSel == status_pkg::SEL_RCOND)  ? runStateCondition :
    (regSel == status_pkg::SEL_REVT)   ? operE.evt :
    (regSel == status_pkg::SEL_RMASK)  ? oMask :
    (regSel == status_pkg::SEL_SEVT)   ? {8'h00, stdE.evt} :
    (regSel == status_pkg::SEL_SMASK)  ? {8'h00, sMask} :
    (regSel == status_pkg::SEL_SRBYTE) ? {8'h00, srqC.srByte} :
    (regSel == status_pkg::SEL_SRMASK) ? {8'h00, srMask} :
    (regSel == status_pkg::SEL_ROLL)   ? {{(16-`NUM_CH){1'b0}}, rollup} :
    (regSel == status_pkg::SEL_CHSUM)  ? chanSummary[regChan] :
    (regSel == status_pkg::SEL_CHMASK) ? chanMask[regChan] :
    16'h0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= regRead;
      if (regRead) begin
        rdData <= rdMux;
      end
    end
  end

  wire wrQ;
  wire wrO;
  wire wrS;
  wire wrSr;
  wire wrCh;

  assign wrQ  = regWrite && (regSel == status_pkg::SEL_QMASK);
  assign wrO  = regWrite && (regSel == status_pkg::SEL_RMASK);
  assign wrS  = regWrite && (regSel == status_pkg::SEL_SMASK);
  assign wrSr = regWrite && (regSel == status_pkg::SEL_SRMASK);
  assign wrCh = regWrite && (regSel == status_pkg::SEL_CHMASK);

  // defaults load takes priority over a write in the same cycle
  always_ff @(posedge clk) begin
    if (rst || defaultsLoad) begin
      qMask    <= `MASK16_RST;
      oMask    <= `MASK16_RST;
      sMask    <= `MASK8_RST;
      srMask   <= `MASK8_RST;
      chanMask <= {`NUM_CH{`CHMASK_RST}};
    end else begin
      if (wrQ) begin
        qMask <= regWData;
      end
      if (wrO) begin
        oMask <= regWData;
      end
      if (wrS) begin
        sMask <= regWData[7:0];
      end
      if (wrSr) begin
        srMask <= regWData[7:0] & `RQS_EXCL;
      end
      if (wrCh) begin
        chanMask[regChan] <= regWData;
      end
    end
  end

  // ***********************************
  // checks
  // ***********************************
  a_run_unused: assert property (@(posedge clk) disable iff (rst)
    (runStateCondition & ~`RUN_USED) == 16'h0000)
    else $error("unused run-state bit set");
  a_run_modes: assert property (@(posedge clk) disable iff (rst)
    ##1 (runStateCondition[`R_CV_BIT] == $past(cvS)
      && runStateCondition[`R_CC_BIT] == $past(ccS)))
    else $error("run-state mode bits wrong");
  a_cmode_block: assert property (@(posedge clk) disable iff (rst)
    quesE.evt[`Q_CMODE_BIT] == 1'b0)
    else $error("current-mode change reached event register");
  a_warn_bit: assert property (@(posedge clk) disable iff (rst)
    (commandWarning && !multiMode) |=> qualityCondition[`Q_WARN_BIT])
    else $error("command warning bit not set");
  a_ques_byte: assert property (@(posedge clk) disable iff (rst)
    (quesE.summary && !multiMode) |=> statusByte[`SB_QUES_BIT])
    else $error("quality event did not set status bit 3");
  a_clean_decode: assert property (@(posedge clk) disable iff (rst)
    (!quesSum && !errQueueNotEmpty) |=> !statusByte[`SB_QUES_BIT])
    else $error("status bit 3 set with no cause");
  a_mav_bit: assert property (@(posedge clk) disable iff (rst)
    msgAvailable |=> statusByte[`SB_MAV_BIT])
    else $error("message available bit missing");
  a_mode_power: assert property (@(posedge clk)
    $past(rst) |-> !multiMode)
    else $error("multi-channel mode active after reset");
  a_rollup_b13: assert property (@(posedge clk) disable iff (rst)
    (multiMode && |rollup) |=> qualityCondition[`Q_ROLL_BIT])
    else $error("rollup did not set quality bit 13");
endmodule

`default_nettype wire

/* host_model.sv */
// host controller model: register reads and writes, structure commands, request line watch
`include "status_params.svh"
`default_nettype none

module host_model (
  input  wire logic                 clk,
  input  wire logic                 srq,
  output var  status_pkg::regsel_t  regSel,
  output var  logic [`CH_IDX_W-1:0] regChan,
  output var  logic                 regRead,
  output var  logic                 regWrite,
  output var  logic [15:0]          regWData,
  output var  logic                 multiOn,
  output var  logic                 multiOff,
  output var  logic                 defaultsLoad
);
  timeunit 1ns;
  timeprecision 100ps;

  int   srqCount = 0;
  logic srqPrev  = 1'b0;

  initial begin
    regSel = status_pkg::SEL_QCOND;
    regChan = '0;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWData = 16'h0000;
    multiOn = 1'b0;
    multiOff = 1'b0;
    defaultsLoad = 1'b0;
  end

  // counts request line rises, sampled away from the launching edge
  always @(negedge clk) begin
    if (srq === 1'b1 && srqPrev !== 1'b1) begin
      srqCount++;
    end
    srqPrev = srq;
  end

  task automatic rd(input status_pkg::regsel_t sel, input logic [`CH_IDX_W-1:0] ch);
    @(posedge clk);
    #1;
    regSel = sel;
    regChan = ch;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
  endtask

  task automatic wr(input status_pkg::regsel_t sel, input logic [`CH_IDX_W-1:0] ch, input logic [15:0] d);
    @(posedge clk);
    #1;
    regSel = sel;
    regChan = ch;
    regWData = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
  endtask

  // 0 structure on, 1 structure off, 2 load mask defaults
  task automatic cmd(input int which);
    @(posedge clk);
    #1;
    multiOn = (which == 0);
    multiOff = (which == 1);
    defaultsLoad = (which == 2);
    @(posedge clk);
    #1;
    multiOn = 1'b0;
    multiOff = 1'b0;
    defaultsLoad = 1'b0;
  endtask
endmodule

`default_nettype wire

/* status_event_reporting_bench.sv */
// self-checking bench for the status and event reporting block
`include "status_params.svh"
`default_nettype none

module status_event_reporting_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                         clk, rst, constVolt, relayClosed, constCurr, voltErr, commandWarning;
  logic                         errQueueNotEmpty, msgAvailable, multiOn, multiOff, defaultsLoad;
  logic                         regRead, regWrite, rdValid, srq, multiMode;
  logic [7:0]                   stdCond, statusByte, m, r;
  logic [`NUM_CH-1:0][15:0]     chanSummary, cs;
  logic [`CH_IDX_W-1:0]         regChan;
  logic [15:0]                  regWData, rdData, orv, roll;
  status_pkg::regsel_t          regSel;
  int                           errorCnt, numChecks;
  logic [15:0]                  expQ[$];
  string                        nameQ[$];

  status_event_reporting u_status_event_reporting (.clk(clk), .rst(rst), .constVolt(constVolt),
    .relayClosed(relayClosed), .constCurr(constCurr), .voltErr(voltErr), .commandWarning(commandWarning),
    .errQueueNotEmpty(errQueueNotEmpty), .msgAvailable(msgAvailable), .stdCond(stdCond),
    .chanSummary(chanSummary), .multiOn(multiOn), .multiOff(multiOff), .defaultsLoad(defaultsLoad),
    .regSel(regSel), .regChan(regChan), .regRead(regRead), .regWrite(regWrite), .regWData(regWData),
    .rdData(rdData), .rdValid(rdValid), .statusByte(statusByte), .srq(srq), .multiMode(multiMode));

  host_model u_host_model (.clk(clk), .srq(srq), .regSel(regSel), .regChan(regChan), .regRead(regRead),
    .regWrite(regWrite), .regWData(regWData), .multiOn(multiOn), .multiOff(multiOff),
    .defaultsLoad(defaultsLoad));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdChk(input string what, input status_pkg::regsel_t sel, input logic [`CH_IDX_W-1:0] ch,
                       input logic [15:0] exp);
    expQ.push_back(exp);
    nameQ.push_back(what);
    u_host_model.rd(sel, ch);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // read results are matched against the oldest note
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        errorCnt++;
        $display("ERROR unexpected read expected none seen %h", rdData);
      end else begin
        check(nameQ.pop_front(), rdData, expQ.pop_front());
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    errorCnt++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errorCnt = 0;
    numChecks = 0;
    rst = 1'b1;
    {constVolt, relayClosed, constCurr, voltErr, commandWarning, errQueueNotEmpty, msgAvailable} = '0;
    stdCond = 8'h00;
    chanSummary = '0;
    void'($urandom(32'hb9b0));
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check("status byte at reset", {8'h00, statusByte}, 16'h0000);
    check("multi mode at reset", {15'h0, multiMode}, 16'h0000);
    rdChk("quality mask reset", status_pkg::SEL_QMASK, 0, 16'h0000);
    rdChk("channel mask reset", status_pkg::SEL_CHMASK, 3, 16'hffff);
    rdChk("request mask reset", status_pkg::SEL_SRMASK, 0, 16'h0000);
    constVolt = 1'b1;
    relayClosed = 1'b1;
    constCurr = 1'b1;
    idle(6);
    rdChk("run state condition", status_pkg::SEL_RCOND, 0, 16'h0700);
    rdChk("quality condition", status_pkg::SEL_QCOND, 0, 16'h0700);
    u_host_model.wr(status_pkg::SEL_QMASK, 0, 16'h0001);
    voltErr = 1'b1;
    idle(6);
    check("status quality bit", {15'h0, statusByte[3]}, 16'h0001);
    rdChk("quality event", status_pkg::SEL_QEVT, 0, 16'h0001);
    rdChk("quality event cleared", status_pkg::SEL_QEVT, 0, 16'h0000);
    idle(3);
    check("status bit3 clean", {15'h0, statusByte[3]}, 16'h0000);
    u_host_model.wr(status_pkg::SEL_QMASK, 0, 16'h0400);
    constCurr = 1'b0;
    idle(6);
    constCurr = 1'b1;
    idle(6);
    rdChk("current mode event", status_pkg::SEL_QEVT, 0, 16'h0000);
    u_host_model.wr(status_pkg::SEL_QMASK, 0, 16'h4000);
    commandWarning = 1'b1;
    idle(3);
    rdChk("warning condition", status_pkg::SEL_QCOND, 0, 16'h4701);
    rdChk("warning event", status_pkg::SEL_QEVT, 0, 16'h4000);
    commandWarning = 1'b0;
    voltErr = 1'b0;
    u_host_model.wr(status_pkg::SEL_QMASK, 0, 16'hffff);
    u_host_model.cmd(2);
    rdChk("mask defaults", status_pkg::SEL_QMASK, 0, 16'h0000);
    u_host_model.wr(status_pkg::SEL_RMASK, 0, 16'h0100);
    rdChk("run mask", status_pkg::SEL_RMASK, 0, 16'h0100);
    constVolt = 1'b0;
    idle(6);
    constVolt = 1'b1;
    idle(6);
    check("status run summary", {8'h00, statusByte}, 16'h0080);
    rdChk("run event", status_pkg::SEL_REVT, 0, 16'h0100);
    rdChk("run event cleared", status_pkg::SEL_REVT, 0, 16'h0000);
    u_host_model.wr(status_pkg::SEL_SRMASK, 0, 16'h00ff);
    rdChk("request mask bit6", status_pkg::SEL_SRMASK, 0, 16'h00bf);
    u_host_model.wr(status_pkg::SEL_SRMASK, 0, 16'h0018);
    msgAvailable = 1'b1;
    idle(3);
    check("status with message", {8'h00, statusByte}, 16'h0050);
    check("request line up", {15'h0, srq}, 16'h0001);
    rdChk("request byte", status_pkg::SEL_SRBYTE, 0, 16'h0050);
    msgAvailable = 1'b0;
    idle(3);
    check("request line down", {15'h0, srq}, 16'h0000);
    errQueueNotEmpty = 1'b1;
    idle(3);
    check("status with queue", {8'h00, statusByte}, 16'h0048);
    errQueueNotEmpty = 1'b0;
    u_host_model.wr(status_pkg::SEL_SRMASK, 0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      m = 8'($urandom);
      r = 8'($urandom);
      u_host_model.wr(status_pkg::SEL_SMASK, 0, {8'h00, m});
      rdChk("std mask", status_pkg::SEL_SMASK, 0, {8'h00, m});
      stdCond = r;
      idle(3);
      check("std summary", {15'h0, statusByte[5]}, {15'h0, |(r & m)});
      rdChk("std event", status_pkg::SEL_SEVT, 0, {8'h00, r & m});
      stdCond = 8'h00;
      idle(2);
    end
    constVolt = 1'b0;
    relayClosed = 1'b0;
    constCurr = 1'b0;
    u_host_model.cmd(0);
    check("multi mode on", {15'h0, multiMode}, 16'h0001);
    orv = 16'h0000;
    roll = 16'h0000;
    for (int k = 0; k < `NUM_CH; k++) begin
      cs[k] = 16'($urandom) | 16'h0001;
      orv = orv | cs[k];
      roll[k] = (k != 1);
    end
    chanSummary = cs;
    u_host_model.wr(status_pkg::SEL_CHMASK, 1, 16'h0000);
    idle(3);
    rdChk("rollup", status_pkg::SEL_ROLL, 0, roll);
    rdChk("multi quality", status_pkg::SEL_QCOND, 0, orv | 16'h2000);
    rdChk("multi event view", status_pkg::SEL_QEVT, 0, orv | 16'h2000);
    rdChk("multi event kept", status_pkg::SEL_QEVT, 0, orv | 16'h2000);
    rdChk("channel summary", status_pkg::SEL_CHSUM, 2, cs[2]);
    chanSummary = '0;
    idle(3);
    rdChk("multi quality clear", status_pkg::SEL_QCOND, 0, 16'h0000);
    u_host_model.cmd(1);
    check("multi mode off", {15'h0, multiMode}, 16'h0000);
    idle(4);
    check("pending reads", 16'(expQ.size()), 16'h0000);
    check("request rises", 16'(u_host_model.srqCount), 16'h0002);
    conclude();
  end
endmodule

`default_nettype wire
